// ===== pkg/amcr_mgmt_if.sv
// Register access strobes between the serial port engine and the bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface amcr_mgmt_if;
	logic rd_stb;
	logic wr_stb;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [4:0] phy_addr;
	logic ready;
	modport engine(output rd_stb, wr_stb, addr, wdata,
		input rdata, phy_addr, ready);
	modport bank(input rd_stb, wr_stb, addr, wdata,
		output rdata, phy_addr, ready);
endinterface

// ===== pkg/amcr_pkg.sv
// Constants shared by the negotiation register bank and its serial port.
// Assumes 5-bit register and station addresses and 16-bit registers.
package amcr_pkg;
	localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
	localparam logic [4:0] REG_ADVERTISE = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_EXPANSION = 5'h06;
	localparam logic [4:0] REG_NP_TRANSMIT = 5'h07;
	localparam logic [4:0] REG_GIG_CONTROL = 5'h09;
	localparam logic [4:0] REG_STRAP_LATCH = 5'h10;
	localparam logic [4:0] REG_LINK_NEG = 5'h11;
	localparam logic [4:0] REG_AUX_CONTROL = 5'h12;
	localparam int BC_RESET = 15;
	localparam int BC_SPEED_LSB = 13;
	localparam int BC_NEG_EN = 12;
	localparam int BC_ISOLATE = 10;
	localparam int BC_RESTART = 9;
	localparam int BC_DUPLEX = 8;
	localparam int BC_SPEED_MSB = 6;
	localparam logic [15:0] BS_ABILITIES = 16'hF909;
	localparam int BS_NEG_DONE = 5;
	localparam int BS_REMOTE_FAULT = 4;
	localparam int BS_LINK = 2;
	localparam int PAGE_NEXT = 15;
	localparam int PAGE_REMOTE_FAULT = 13;
	localparam int ADV_100FD = 8;
	localparam int ADV_100HD = 7;
	localparam int ADV_10FD = 6;
	localparam int ADV_10HD = 5;
	localparam logic [15:0] ADV_SELECTOR = 16'h0001;
	localparam int GIG_1000FD = 9;
	localparam int GIG_1000HD = 8;
	localparam int EXP_PD_FAULT = 4;
	localparam int EXP_LP_NP = 3;
	localparam int EXP_LOCAL_NP = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_LP_NEG = 0;
	localparam int AUX_XOVER_DIS = 15;
	localparam int AUX_XOVER_CROSS = 14;
	localparam int LNS_POL_LSB = 12;
	localparam int LNS_SWAPPED = 5;
	localparam int STRAP_NEG_EN = 15;
	localparam int STRAP_DUPLEX = 14;
	localparam int STRAP_SPEED_HI = 13;
	localparam int STRAP_SPEED_LO = 12;
	localparam int STRAP_XOVER_AUTO = 11;
	localparam int STRAP_XOVER_MAN = 10;
	localparam logic [4:0] ISOLATE_ADDR = 5'h00;
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0B;
	localparam logic [4:0] DATA_LAST = 5'h0F;
endpackage

// ===== rtl/amcr_mdio_slave.sv
// Serial management frame engine: preamble, start, opcode, addresses,
// turnaround and 16 data bits. Assumes MDC and MDIO are asynchronous pins.
`timescale 1ns/1ps
module amcr_mdio_slave
	import amcr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	amcr_mgmt_if.engine bus
);
	typedef enum logic [2:0] {PH_PRE, PH_ST, PH_HDR, PH_TA, PH_DATA} amcr_ph_t;
	typedef struct packed {
		logic mdc_s1;
		logic mdc_s2;
		logic mdc_s3;
		logic io_s1;
		logic io_s2;
		amcr_ph_t ph;
		logic [5:0] ones;
		logic [4:0] cnt;
		logic [11:0] hdr;
		logic [15:0] sh;
		logic match;
		logic out;
		logic oe;
		logic rd;
		logic wr;
	} amcr_mdio_t;
	amcr_mdio_t r_reg, r_next;
	logic bit_in;
	logic rise;
	assign bit_in = r_reg.io_s2;
	assign rise = r_reg.mdc_s2 & ~r_reg.mdc_s3;
	always_comb begin
		r_next = r_reg;
		r_next.rd = 1'b0;
		r_next.wr = 1'b0;
		r_next.mdc_s1 = mdc_i;
		r_next.mdc_s2 = r_reg.mdc_s1;
		r_next.mdc_s3 = r_reg.mdc_s2;
		r_next.io_s1 = mdio_i;
		r_next.io_s2 = r_reg.io_s1;
		if (rise) begin
			case (r_reg.ph)
				PH_PRE: begin
					if (bit_in && r_reg.ones != PREAMBLE_LEN)
						r_next.ones = r_reg.ones + 6'h01;
					else if (!bit_in && r_reg.ones == PREAMBLE_LEN)
						r_next.ph = PH_ST;
					else if (!bit_in)
						r_next.ones = 6'h00;
				end
				PH_ST: begin
					r_next.ones = 6'h00;
					r_next.cnt = 5'h00;
					r_next.ph = bit_in ? PH_HDR : PH_PRE;
				end
				PH_HDR: begin
					r_next.hdr = {r_reg.hdr[10:0], bit_in};
					r_next.cnt = r_reg.cnt + 5'h01;
					if (r_reg.cnt == HDR_LAST) begin
						r_next.ph = PH_TA;
						r_next.cnt = 5'h00;
						r_next.match = bus.ready &&
							r_next.hdr[9:5] == bus.phy_addr;
					end
				end
				PH_TA: begin
					r_next.cnt = r_reg.cnt + 5'h01;
					if (r_reg.hdr[11:10] == OP_READ && r_reg.match) begin
						// Slot two of the turnaround is driven low.
						r_next.oe = 1'b1;
						r_next.rd = r_reg.cnt == 5'h00;
						// The word is taken once, before the read strobe,
						// so clear-on-read bits return their old value.
						if (r_reg.cnt == 5'h00) begin
							r_next.out = 1'b0;
							r_next.sh = bus.rdata;
						end else begin
							r_next.out = r_reg.sh[15];
							r_next.sh = {r_reg.sh[14:0], 1'b0};
						end
					end
					if (r_reg.cnt != 5'h00) begin
						r_next.ph = PH_DATA;
						r_next.cnt = 5'h00;
					end
				end
				PH_DATA: begin
					r_next.cnt = r_reg.cnt + 5'h01;
					if (r_reg.hdr[11:10] == OP_READ) begin
						r_next.out = r_reg.sh[15];
						r_next.sh = {r_reg.sh[14:0], 1'b0};
					end else
						r_next.sh = {r_reg.sh[14:0], bit_in};
					if (r_reg.cnt == DATA_LAST) begin
						r_next.ph = PH_PRE;
						r_next.oe = 1'b0;
						r_next.wr = r_reg.match &&
							r_reg.hdr[11:10] == OP_WRITE;
					end
				end
				default: r_next.ph = PH_PRE;
			endcase
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			r_reg <= '0;
		else if (ce_i)
			r_reg <= r_next;
	end
	assign mdio_o = r_reg.out;
	assign mdio_oe_o = r_reg.oe;
	assign bus.rd_stb = r_reg.rd;
	assign bus.wr_stb = r_reg.wr;
	assign bus.addr = r_reg.hdr[4:0];
	assign bus.wdata = r_reg.sh;
endmodule // amcr_mdio_slave

// ===== rtl/amcr_regs.sv
// Negotiation, crossover and strap register bank of a tri-speed transceiver.
// Assumes link-pulse, receive and crossover detectors share CLK_I; straps
// and the management pins are asynchronous.
//
// How it works
// - Register writes override strap-initialised settings.
// - Send advertisement and gigabit abilities while negotiating.
// - Straps choose duplex and advertised speeds.
// - Resolve highest common mode with partner.
// - Report result in control and status.
// - Status ability bits are the fixed constant F909.
// - Status bits five, four, two report progress.
// - Advertisement defaults to strapped modes; cleared bits are withheld.
// - Partner register takes base then each page.
// - Base page overwritten by next pages; page-received flag marks arrival.
// - Expansion bits report fault, pages, partner ability.
// - Swap A/B, and C/D at gigabit.
// - Crossover resolves before pulse bursts start.
// - Crossover straps pick automatic or fixed wiring.
// - Auxiliary bits override the crossover straps.
// - Crossover runs in negotiated and forced modes.
// - Show per-pair polarity reversal in bits 15:12.
// - Address strapped; zero isolates at power-up.
// - Latch all straps into read-only register.
// - Shared LED pin polarity opposes its strap.
// - Writing restart bit reruns negotiation.
`timescale 1ns/1ps
module amcr_regs
	import amcr_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	input wire logic MDC_I,
	input wire logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE_O,
	input wire logic NEGOTIATION_ENABLE_STRAP_I,
	input wire logic DUPLEX_STRAP_I,
	input wire logic SPEED_STRAP_HI_I,
	input wire logic SPEED_STRAP_LO_I,
	input wire logic CROSSOVER_AUTO_STRAP_I,
	input wire logic CROSSOVER_MANUAL_STRAP_I,
	input wire logic [4:0] PHY_ADDR_STRAP_I,
	input wire logic PAGE_RX_VALID_I,
	input wire logic [15:0] PAGE_RX_DATA_I,
	input wire logic [1:0] PARTNER_GIG_ABILITY_I,
	input wire logic PARALLEL_FAULT_I,
	input wire logic LINK_OK_I,
	input wire logic CROSS_LOCK_I,
	input wire logic CROSS_DETECTED_I,
	input wire logic [3:0] POLARITY_REV_I,
	output logic FLP_ENABLE_O,
	output logic [15:0] PAGE_TX_DATA_O,
	output logic [15:0] GIG_TX_DATA_O,
	output logic [1:0] SPEED_O,
	output logic FULL_DUPLEX_O,
	output logic SWAP_AB_O,
	output logic SWAP_CD_O,
	output logic [3:0] POLARITY_INVERT_O,
	output logic ISOLATE_O,
	output logic DUPLEX_LED_O,
	output logic DUPLEX_LED_OE_O
);
	typedef enum logic [2:0] {
		ST_LATCH, ST_XOVER, ST_BASE, ST_NEXT, ST_DONE, ST_FORCED
	} amcr_state_t;
	typedef struct packed {
		amcr_state_t st;
		logic [10:0] sync1;
		logic [10:0] sync2;
		logic [1:0] settle;
		logic [15:0] strap;
		logic [15:0] bc;
		logic [15:0] adv;
		logic [15:0] lpa;
		logic [15:0] npt;
		logic [15:0] gig;
		logic [15:0] aux;
		logic page_rx;
		logic pd_fault;
		logic lp_neg;
		logic np_loaded;
		logic neg_done;
		logic link;
		logic swap;
		logic swap_cd;
		logic [3:0] pol;
		logic flp;
		logic [15:0] tx_page;
		logic [1:0] speed;
		logic fdx;
		logic led;
		logic led_oe;
	} amcr_state_reg_t;
	amcr_state_reg_t r_reg, r_next;
	amcr_mgmt_if mgmt();
	amcr_mdio_slave u_mdio (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.ce_i(CE_I),
		.mdc_i(MDC_I),
		.mdio_i(MDIO_I),
		.mdio_o(MDIO_O),
		.mdio_oe_o(MDIO_OE_O),
		.bus(mgmt)
	);
	// Returns {found, speed, full duplex} for the best shared mode.
	function automatic logic [3:0] resolve(input logic [15:0] adv,
		input logic [15:0] lpa, input logic [15:0] gig,
		input logic [1:0] pgig);
		logic [15:0] common;
		common = adv & lpa;
		if (gig[GIG_1000FD] && pgig[1])
			resolve = {1'b1, SPEED_1000, 1'b1};
		else if (gig[GIG_1000HD] && pgig[0])
			resolve = {1'b1, SPEED_1000, 1'b0};
		else if (common[ADV_100FD])
			resolve = {1'b1, SPEED_100, 1'b1};
		else if (common[ADV_100HD])
			resolve = {1'b1, SPEED_100, 1'b0};
		else if (common[ADV_10FD])
			resolve = {1'b1, SPEED_10, 1'b1};
		else if (common[ADV_10HD])
			resolve = {1'b1, SPEED_10, 1'b0};
		else
			resolve = {1'b0, SPEED_10, 1'b0};
	endfunction
	function automatic logic [15:0] read_reg(input logic [4:0] a,
		input amcr_state_reg_t s);
		case (a)
			REG_BASIC_CONTROL: read_reg = s.bc;
			REG_BASIC_STATUS: begin
				read_reg = BS_ABILITIES;
				read_reg[BS_NEG_DONE] = s.neg_done;
				read_reg[BS_REMOTE_FAULT] = s.lpa[PAGE_REMOTE_FAULT];
				read_reg[BS_LINK] = s.link;
			end
			REG_ADVERTISE: read_reg = s.adv;
			REG_PARTNER: read_reg = s.lpa;
			REG_EXPANSION: begin
				read_reg = 16'h0000;
				read_reg[EXP_PD_FAULT] = s.pd_fault;
				read_reg[EXP_LP_NP] = s.lpa[PAGE_NEXT];
				read_reg[EXP_LOCAL_NP] = 1'b1;
				read_reg[EXP_PAGE_RX] = s.page_rx;
				read_reg[EXP_LP_NEG] = s.lp_neg;
			end
			REG_NP_TRANSMIT: read_reg = s.npt;
			REG_GIG_CONTROL: read_reg = s.gig;
			REG_STRAP_LATCH: read_reg = s.strap;
			REG_LINK_NEG: begin
				read_reg = 16'h0000;
				read_reg[LNS_POL_LSB +: 4] = s.pol;
				read_reg[LNS_SWAPPED] = s.swap;
			end
			REG_AUX_CONTROL: read_reg = s.aux;
			default: read_reg = 16'h0000;
		endcase
	endfunction
	logic [3:0] res;
	logic xover_auto;
	logic xover_cross;
	logic [10:0] strap_pins;
	assign res = resolve(r_reg.adv, r_reg.lpa, r_reg.gig,
		PARTNER_GIG_ABILITY_I);
	// An auxiliary override takes precedence over both crossover straps.
	assign xover_auto = r_reg.strap[STRAP_XOVER_AUTO] &
		~r_reg.aux[AUX_XOVER_DIS];
	assign xover_cross = r_reg.aux[AUX_XOVER_DIS] ?
		r_reg.aux[AUX_XOVER_CROSS] : r_reg.strap[STRAP_XOVER_MAN];
	assign strap_pins = {NEGOTIATION_ENABLE_STRAP_I, DUPLEX_STRAP_I,
		SPEED_STRAP_HI_I, SPEED_STRAP_LO_I, CROSSOVER_AUTO_STRAP_I,
		CROSSOVER_MANUAL_STRAP_I, PHY_ADDR_STRAP_I};
	assign mgmt.rdata = read_reg(mgmt.addr, r_reg);
	assign mgmt.phy_addr = r_reg.strap[4:0];
	assign mgmt.ready = r_reg.st != ST_LATCH;
	always_comb begin
		r_next = r_reg;
		r_next.sync1 = strap_pins;
		r_next.sync2 = r_reg.sync1;
		r_next.pol = POLARITY_REV_I;
		r_next.link = LINK_OK_I;
		if (r_reg.st == ST_LATCH) begin
			// Wait for the strap synchronisers to fill before sampling.
			r_next.settle = r_reg.settle + 2'h1;
			if (r_reg.settle == STRAP_SETTLE) begin
				r_next.strap = {r_reg.sync2[10:5], 5'h00, r_reg.sync2[4:0]};
				r_next.bc = 16'h0000;
				r_next.bc[BC_NEG_EN] = r_reg.sync2[10];
				r_next.bc[BC_DUPLEX] = r_reg.sync2[9];
				if (!r_reg.sync2[10]) begin
					r_next.bc[BC_SPEED_MSB] = r_reg.sync2[8];
					r_next.bc[BC_SPEED_LSB] = r_reg.sync2[7];
				end
				r_next.bc[BC_ISOLATE] = r_reg.sync2[4:0] == ISOLATE_ADDR;
				// Speed straps pick the 10/100 abilities; gigabit is
				// always offered and duplex halves or keeps every mode.
				r_next.adv = ADV_SELECTOR;
				r_next.adv[ADV_10FD] = r_reg.sync2[9] & (&r_reg.sync2[8:7]);
				r_next.adv[ADV_10HD] = ~r_reg.sync2[9] & (&r_reg.sync2[8:7]);
				r_next.adv[ADV_100FD] = r_reg.sync2[9] & ~r_reg.sync2[8];
				r_next.adv[ADV_100HD] = ~r_reg.sync2[9] & ~r_reg.sync2[8];
				if (r_reg.sync2[8:7] == 2'h0) begin
					r_next.adv[ADV_10FD] = r_reg.sync2[9];
					r_next.adv[ADV_10HD] = ~r_reg.sync2[9];
				end
				r_next.gig = 16'h0000;
				r_next.gig[GIG_1000FD] = r_reg.sync2[9];
				r_next.gig[GIG_1000HD] = ~r_reg.sync2[9];
				r_next.st = ST_XOVER;
			end
		end else begin
			if (mgmt.rd_stb && mgmt.addr == REG_EXPANSION) begin
				r_next.page_rx = 1'b0;
				r_next.pd_fault = 1'b0;
			end
			if (mgmt.wr_stb) begin
				case (mgmt.addr)
					REG_BASIC_CONTROL: begin
						r_next.bc = mgmt.wdata;
						r_next.bc[BC_RESTART] = 1'b0;
						r_next.bc[BC_RESET] = 1'b0;
						if (mgmt.wdata[BC_RESTART] ||
							mgmt.wdata[BC_NEG_EN] != r_reg.bc[BC_NEG_EN])
							r_next.st = ST_XOVER;
					end
					REG_ADVERTISE: r_next.adv = mgmt.wdata;
					REG_NP_TRANSMIT: begin
						r_next.npt = mgmt.wdata;
						r_next.np_loaded = 1'b1;
					end
					REG_GIG_CONTROL: r_next.gig = mgmt.wdata;
					REG_AUX_CONTROL: begin
						r_next.aux = mgmt.wdata;
						r_next.st = ST_XOVER;
					end
					default: ;
				endcase
			end
			// A fault or page that coincides with the read still sets.
			if (PARALLEL_FAULT_I)
				r_next.pd_fault = 1'b1;
			case (r_reg.st)
				ST_XOVER: begin
					r_next.neg_done = 1'b0;
					r_next.flp = 1'b0;
					if (!xover_auto) begin
						r_next.swap = xover_cross;
						r_next.st = r_reg.bc[BC_NEG_EN] ? ST_BASE : ST_FORCED;
					end else if (CROSS_LOCK_I) begin
						r_next.swap = CROSS_DETECTED_I;
						r_next.st = r_reg.bc[BC_NEG_EN] ?
							ST_BASE : ST_FORCED;
					end
					if (r_next.st == ST_BASE) begin
						r_next.page_rx = 1'b0;
						r_next.lp_neg = 1'b0;
						r_next.np_loaded = 1'b0;
					end
				end
				ST_BASE: begin
					r_next.flp = 1'b1;
					r_next.tx_page = r_reg.adv;
					if (PAGE_RX_VALID_I) begin
						r_next.lpa = PAGE_RX_DATA_I;
						r_next.page_rx = 1'b1;
						r_next.lp_neg = 1'b1;
						if (PAGE_RX_DATA_I[PAGE_NEXT] || r_reg.adv[PAGE_NEXT])
							r_next.st = ST_NEXT;
						else
							r_next.st = ST_DONE;
					end
				end
				ST_NEXT: begin
					// Bursts pause until the manager loads the next page.
					r_next.flp = r_reg.np_loaded;
					r_next.tx_page = r_reg.npt;
					if (PAGE_RX_VALID_I) begin
						r_next.lpa = PAGE_RX_DATA_I;
						r_next.page_rx = 1'b1;
						r_next.np_loaded = 1'b0;
						if (!PAGE_RX_DATA_I[PAGE_NEXT] &&
							!r_reg.npt[PAGE_NEXT])
							r_next.st = ST_DONE;
					end
				end
				ST_DONE: begin
					r_next.flp = 1'b0;
					r_next.neg_done = res[3];
					r_next.speed = res[2:1];
					r_next.fdx = res[0];
					r_next.bc[BC_SPEED_MSB] = res[2];
					r_next.bc[BC_SPEED_LSB] = res[1];
					r_next.bc[BC_DUPLEX] = res[0];
					// Losing the link or finding no shared mode renegotiates.
					if (!res[3] || (r_reg.neg_done && !LINK_OK_I))
						r_next.st = ST_XOVER;
				end
				ST_FORCED: begin
					r_next.flp = 1'b0;
					r_next.speed = {r_reg.bc[BC_SPEED_MSB],
						r_reg.bc[BC_SPEED_LSB]};
					r_next.fdx = r_reg.bc[BC_DUPLEX];
				end
				default: r_next.st = ST_XOVER;
			endcase
			r_next.swap_cd = r_next.swap & (r_next.speed == SPEED_1000);
			if (PAGE_RX_VALID_I &&
				(r_reg.st == ST_BASE || r_reg.st == ST_NEXT))
				r_next.page_rx = 1'b1;
			// The pin idles as a strap input until the value is held.
			r_next.led_oe = 1'b1;
			r_next.led = (r_reg.fdx & r_reg.link) ^
				r_reg.strap[0];
		end
	end
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			r_reg <= '0;
		else if (CE_I)
			r_reg <= r_next;
	end
	assign FLP_ENABLE_O = r_reg.flp;
	assign PAGE_TX_DATA_O = r_reg.tx_page;
	assign GIG_TX_DATA_O = r_reg.gig;
	assign SPEED_O = r_reg.speed;
	assign FULL_DUPLEX_O = r_reg.fdx;
	assign SWAP_AB_O = r_reg.swap;
	assign SWAP_CD_O = r_reg.swap_cd;
	assign POLARITY_INVERT_O = r_reg.pol;
	assign ISOLATE_O = r_reg.bc[BC_ISOLATE];
	assign DUPLEX_LED_O = r_reg.led;
	assign DUPLEX_LED_OE_O = r_reg.led_oe;
endmodule // amcr_regs

// ===== verification/amcr_regs_asserts.sv
// Checker for the negotiation register bank, on its top-level ports only.
// Assumes one clock domain and a management clock far slower than CLK_I.
`timescale 1ns/1ps
module amcr_regs_asserts
	import amcr_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	input wire logic MDIO_O,
	input wire logic MDIO_OE_O,
	input wire logic [4:0] PHY_ADDR_STRAP_I,
	input wire logic CROSS_LOCK_I,
	input wire logic LINK_OK_I,
	input wire logic [3:0] POLARITY_REV_I,
	input wire logic FLP_ENABLE_O,
	input wire logic [1:0] SPEED_O,
	input wire logic FULL_DUPLEX_O,
	input wire logic SWAP_AB_O,
	input wire logic SWAP_CD_O,
	input wire logic [3:0] POLARITY_INVERT_O,
	input wire logic DUPLEX_LED_O,
	input wire logic DUPLEX_LED_OE_O
);
	logic lock_seen;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	// Bursts may only start once the crossover detector has decided.
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lock_seen <= 1'b0;
		end else if (CE_I && CROSS_LOCK_I) begin
			lock_seen <= 1'b1;
		end
	end
	property p_pol;
		$past(CE_I) && $past(RST_B_I, 2) |->
			POLARITY_INVERT_O == $past(POLARITY_REV_I);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity lag wrong");
	property p_cd;
		SWAP_CD_O |-> SWAP_AB_O && SPEED_O == SPEED_1000;
	endproperty
	a_cd: assert property (p_cd) else $error("pair C/D swap wrong");
	property p_ta;
		$rose(MDIO_OE_O) |-> !MDIO_O;
	endproperty
	a_ta: assert property (p_ta) else $error("turnaround not zero");
	property p_hold;
		$rose(MDIO_OE_O) |-> MDIO_OE_O [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("read drive short");
	property p_flp;
		$rose(FLP_ENABLE_O) |-> lock_seen;
	endproperty
	a_flp: assert property (p_flp) else $error("bursts before lock");
	property p_speed;
		SPEED_O != 2'h3;
	endproperty
	a_speed: assert property (p_speed) else $error("bad speed code");
	property p_early;
		$rose(MDIO_OE_O) |-> $past(RST_B_I, 5);
	endproperty
	a_early: assert property (p_early) else $error("drive before latch");
	property p_led;
		DUPLEX_LED_OE_O && $past(DUPLEX_LED_OE_O) && $stable(FULL_DUPLEX_O)
			&& $past(CE_I) && $past(CE_I, 2) |-> DUPLEX_LED_O ==
			((FULL_DUPLEX_O & $past(LINK_OK_I, 2)) ^ PHY_ADDR_STRAP_I[0]);
	endproperty
	a_led: assert property (p_led) else $error("LED polarity wrong");
endmodule // amcr_regs_asserts

bind amcr_regs amcr_regs_asserts u_asserts (
	.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .MDIO_O(MDIO_O),
	.MDIO_OE_O(MDIO_OE_O), .PHY_ADDR_STRAP_I(PHY_ADDR_STRAP_I),
	.CROSS_LOCK_I(CROSS_LOCK_I), .LINK_OK_I(LINK_OK_I),
	.POLARITY_REV_I(POLARITY_REV_I),
	.FLP_ENABLE_O(FLP_ENABLE_O), .SPEED_O(SPEED_O),
	.FULL_DUPLEX_O(FULL_DUPLEX_O), .SWAP_AB_O(SWAP_AB_O),
	.SWAP_CD_O(SWAP_CD_O), .POLARITY_INVERT_O(POLARITY_INVERT_O),
	.DUPLEX_LED_O(DUPLEX_LED_O), .DUPLEX_LED_OE_O(DUPLEX_LED_OE_O)
);

// ===== verification/amcr_station.sv
// Station manager model: runs management frames on the serial pins.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module amcr_station
	import amcr_pkg::*;
(
	input wire logic clk_i,
	input wire logic mdio_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o,
	output logic [15:0] rdata_o,
	output logic done_o
);
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
		rdata_o = 16'h0000;
		done_o = 1'b0;
	end
	// Sixteen system clocks per bit, so the synchronisers see every edge.
	task automatic mbit(input logic en, input logic b, output logic s);
		mdio_oe_o = en;
		mdio_o = b;
		repeat (8) @(posedge clk_i);
		s = mdio_i;
		#1 mdc_o = 1'b1;
		repeat (8) @(posedge clk_i);
		#1 mdc_o = 1'b0;
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] rg, input logic [15:0] wd);
		logic [45:0] hdr;
		logic s;
		logic rd;
		hdr = {32'hFFFFFFFF, 2'b01, op, phy, rg};
		rd = (op == OP_READ);
		for (int i = 45; i >= 0; i--) begin
			mbit(1'b1, hdr[i], s);
		end
		mbit(!rd, 1'b1, s);
		mbit(!rd, 1'b0, s);
		for (int i = 15; i >= 0; i--) begin
			mbit(!rd, wd[i], s);
			rdata_o[i] = s;
		end
		mdio_oe_o = 1'b0;
		if (rd) begin
			done_o = 1'b1;
			@(posedge clk_i);
			#1 done_o = 1'b0;
		end
	endtask
endmodule // amcr_station

// ===== verification/autoneg_mdix_config_regs_tb_top.sv
// Bench for the negotiation register bank, driven through its serial port.
// Assumes the station model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module autoneg_mdix_config_regs_tb_top;
	import amcr_pkg::*;
	localparam logic [4:0] STATION = 5'h05;
	logic clk, rst_b, ce, mdc, mdio_w, d_mdio, d_oe, m_out, m_oe, done;
	logic pv, pflt, link, xlock, xdet, flp;
	logic sab, scd, fdx, led, loe, iso;
	logic [1:0] spd;
	logic [15:0] ptx, gtx;
	logic [5:0] st;
	logic [15:0] pd, rdata, rnd, e, m;
	logic [1:0] pgig;
	logic [3:0] pol;
	logic [15:0] exp_q[$], msk_q[$];
	string nm_q[$];
	int err_count, checked;

	// Nobody driving leaves the line at its pull-up level.
	assign mdio_w = d_oe ? d_mdio : (m_oe ? m_out : 1'b1);

	amcr_station u_sta (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc),
		.mdio_o(m_out), .mdio_oe_o(m_oe), .rdata_o(rdata), .done_o(done));

	amcr_regs u_dut (
		.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .MDC_I(mdc),
		.MDIO_I(mdio_w), .MDIO_O(d_mdio), .MDIO_OE_O(d_oe),
		.NEGOTIATION_ENABLE_STRAP_I(st[5]), .DUPLEX_STRAP_I(st[4]),
		.SPEED_STRAP_HI_I(st[3]), .SPEED_STRAP_LO_I(st[2]),
		.CROSSOVER_AUTO_STRAP_I(st[1]), .CROSSOVER_MANUAL_STRAP_I(st[0]),
		.PHY_ADDR_STRAP_I(STATION), .PAGE_RX_VALID_I(pv),
		.PAGE_RX_DATA_I(pd), .PARTNER_GIG_ABILITY_I(pgig),
		.PARALLEL_FAULT_I(pflt), .LINK_OK_I(link), .CROSS_LOCK_I(xlock),
		.CROSS_DETECTED_I(xdet), .POLARITY_REV_I(pol), .FLP_ENABLE_O(flp),
		.PAGE_TX_DATA_O(ptx), .GIG_TX_DATA_O(gtx), .SPEED_O(spd),
		.FULL_DUPLEX_O(fdx), .SWAP_AB_O(sab), .SWAP_CD_O(scd),
		.POLARITY_INVERT_O(), .ISOLATE_O(iso),
		.DUPLEX_LED_O(led), .DUPLEX_LED_OE_O(loe)
	);

	task automatic check(string nm, logic [15:0] ex, logic [15:0] got);
		checked++;
		if (got !== ex) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The note is queued first; the monitor compares when the frame ends.
	task automatic rdp(logic [4:0] phy, logic [4:0] rg, logic [15:0] ex,
		logic [15:0] mk, string nm);
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		nm_q.push_back(nm);
		u_sta.frame(OP_READ, phy, rg, 16'h0000);
	endtask

	task automatic rd(logic [4:0] rg, logic [15:0] ex, logic [15:0] mk,
		string nm);
		rdp(STATION, rg, ex, mk, nm);
	endtask

	task automatic wr(logic [4:0] rg, logic [15:0] d);
		u_sta.frame(OP_WRITE, STATION, rg, d);
	endtask

	task automatic page(logic [15:0] d);
		@(posedge clk);
		#1 pv = 1'b1;
		pd = d;
		@(posedge clk);
		#1 pv = 1'b0;
	endtask

	always @(posedge done) begin
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		check(nm_q.pop_front(), e & m, rdata & m);
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (80000) @(posedge clk);
		$display("wait limit reached");
		err_count++;
		stop_test();
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		st = 6'b110110;
		{pv, pflt, link, xlock, xdet} = 5'b00000;
		pd = 16'h0000;
		pgig = 2'h0;
		pol = 4'h0;
		err_count = 0;
		checked = 0;
		rnd = 16'($urandom(32'hB563));
		repeat (16) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		rd(REG_STRAP_LATCH, 16'hD805, 16'hFC1F, "strap_latch");
		rd(REG_BASIC_STATUS, BS_ABILITIES, 16'hFFCB, "abilities");
		rd(REG_ADVERTISE, 16'h0100, 16'h01E0, "adv_strap");
		rd(REG_GIG_CONTROL, 16'h0200, 16'h0300, "gig_strap");
		wr(REG_ADVERTISE, 16'h0021);
		rd(REG_ADVERTISE, 16'h0021, 16'hFFFF, "adv_write");
		wr(5'h03, rnd);
		rd(5'h03, 16'h0000, 16'hFFFF, "unmapped");
		rdp(STATION + 5'h01, REG_ADVERTISE, 16'hFFFF, 16'hFFFF, "other");
		@(posedge clk);
		#1 pol = 4'($urandom());
		rd(REG_LINK_NEG, {pol, 12'h000}, 16'hF000, "polarity");
		@(posedge clk);
		#1 xdet = 1'b1;
		pgig = 2'h2;
		xlock = 1'b1;
		@(posedge clk);
		#1 xlock = 1'b0;
		for (int n = 0; n < 4000 && !flp; n++) begin
			@(posedge clk);
		end
		check("bursts", 16'h0001, {15'h0000, flp});
		if (!flp) stop_test();
		check("tx_page", 16'h0021, ptx);
		check("tx_gig", 16'h0200, gtx);
		check("isolate", 16'h0000, {15'h0000, iso});
		rnd = 16'h8000 | 16'($urandom());
		page(rnd);
		rd(REG_PARTNER, rnd, 16'hFFFF, "base_page");
		rd(REG_EXPANSION, 16'h0002, 16'h0002, "page_rx");
		rd(REG_EXPANSION, 16'h0000, 16'h0002, "page_rx_clr");
		// More pages follow, so the manager loads its own next page.
		if (rnd[PAGE_NEXT] === 1'b1) begin
			rnd = 16'($urandom());
			wr(REG_NP_TRANSMIT, rnd);
			rd(REG_NP_TRANSMIT, rnd, 16'hFFFF, "np_transmit");
		end
		rnd = 16'($urandom()) & 16'h7FFF;
		page(rnd);
		rd(REG_PARTNER, rnd, 16'hFFFF, "next_page");
		wr(REG_AUX_CONTROL, 16'hC000);
		rd(REG_AUX_CONTROL, 16'hC000, 16'hC000, "aux_override");
		wr(REG_BASIC_CONTROL, 16'h1200);
		rd(REG_STRAP_LATCH, 16'hD805, 16'hFC1F, "strap_kept");
		// A base page without more pages ends in the gigabit full mode.
		link = 1'b1;
		page(16'h2021);
		rd(REG_BASIC_CONTROL, 16'h1140, 16'hFFFF, "resolved");
		rd(REG_BASIC_STATUS, 16'hF93D, 16'hFFFF, "neg_status");
		check("link_out", 16'h0075, {9'h000, sab, scd, spd, fdx, led, loe});
		stop_test();
	end
endmodule // autoneg_mdix_config_regs_tb_top
